// File: hdl/rtc_pkg.sv
// Purpose: Shared constants and types for the radio test, timer and coexistence register slice.
// Assumes: 32-bit Avalon-MM byte addressing; every register is one aligned word.
// Notes:   Register layouts are packed structs, so field positions live in the struct order.
package rtc_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] RTC_ADR_RX_TAG    = 32'h400000DC;
	localparam logic [31:0] RTC_ADR_TEST_CTRL = 32'h400000E0;
	localparam logic [31:0] RTC_ADR_TX_TOTAL  = 32'h400000E4;
	localparam logic [31:0] RTC_ADR_RX_TOTAL  = 32'h400000E8;
	localparam logic [31:0] RTC_ADR_TIMGEN    = 32'h400000F0;
	localparam logic [31:0] RTC_ADR_COARSE    = 32'h400000F4;
	localparam logic [31:0] RTC_ADR_FINE      = 32'h400000F8;
	localparam logic [31:0] RTC_ADR_CAPTURE   = 32'h400000FC;
	localparam logic [31:0] RTC_ADR_COEX      = 32'h40000100;
	localparam logic [31:0] RTC_ADR_CAPT_VAL  = 32'h40000110;

	// ----------------------------------------------------------------
	// Writable bit masks, reset values, capture bit and generator parameters
	// ----------------------------------------------------------------
	localparam logic [31:0] RTC_TEST_WMASK   = 32'h8800F9FF;
	localparam logic [31:0] RTC_TIMGEN_WMASK = 32'h83FF01FF;
	localparam logic [31:0] RTC_COARSE_WMASK = 32'h007FFFFF;
	localparam logic [31:0] RTC_FINE_WMASK   = 32'h07FFFFFF;
	localparam logic [31:0] RTC_COEX_WMASK   = 32'h003300F3;
	localparam logic [31:0] RTC_TIMGEN_RST   = 32'h81FE0096;
	localparam logic [31:0] RTC_COEX_RST     = 32'h00000010;
	localparam int          RTC_CAPTURE_BIT  = 0;
	localparam int          RTC_PRBS9_LEN    = 9;
	localparam int          RTC_PRBS9_TAP    = 5;
	localparam int          RTC_PRBS15_LEN   = 15;
	localparam int          RTC_PRBS15_TAP   = 14;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {RTC_IND_NO_PWRUP, RTC_IND_WITH_PWRUP, RTC_IND_HIGH_PRIO, RTC_IND_UNUSED} rtc_ind_e;
	typedef enum logic {RTC_BUS_IDLE, RTC_BUS_ANSWER} rtc_bus_e;

	typedef struct packed {
		logic       endless_receive_window;
		logic [2:0] rsv0;
		logic       rx_good_count_enable;
		logic [10:0] rsv1;
		logic       endless_transmit_payload;
		logic       tx_size_select;
		logic       pseudo_random_poly_select;
		logic       tx_payload_origin;
		logic       tx_sent_count_enable;
		logic [1:0] rsv2;
		logic [8:0] test_tx_byte_count;
	} rtc_test_ctrl_s;

	typedef struct packed {
		logic       early_fetch_abort_enable;
		logic [4:0] rsv0;
		logic [9:0] fetch_abort_instant;
		logic [6:0] rsv1;
		logic [8:0] table_fetch_instant;
	} rtc_timgen_s;

	typedef struct packed {
		logic [9:0] rsv0;
		rtc_ind_e   rx_coex_indicator_mode;
		logic [1:0] rsv1;
		rtc_ind_e   tx_coex_indicator_mode;
		logic [7:0] rsv2;
		logic [1:0] peer_transmit_block_policy;
		logic [1:0] peer_receive_block_policy;
		logic [1:0] rsv3;
		logic       sync_pulse_enable;
		logic       coexist_port_enable;
	} rtc_coex_s;

	typedef struct packed {
		rtc_bus_e       bus;
		logic           waitreq;
		logic [31:0]    rdata;
		rtc_test_ctrl_s test;
		rtc_timgen_s    tim;
		rtc_coex_s      coex;
		logic [22:0]    coarse_alarm_value;
		logic [26:0]    fine_alarm_value;
		logic [31:0]    rx_integrity_tag;
		logic [31:0]    tx_live;
		logic [31:0]    rx_live;
		logic [31:0]    tx_sent_total;
		logic [31:0]    rx_good_total;
		logic [26:0]    captured_time;
		logic           capture_time_trigger;
		logic [1:0]     peer_tx_sync;
		logic [1:0]     peer_rx_sync;
		logic           coarse_hit;
		logic           fine_hit;
		logic           coarse_alarm;
		logic           fine_alarm;
		logic           coex_tx;
		logic           coex_rx;
		logic           tx_abort;
		logic           rx_abort;
		logic           sync_pulse;
		logic           endless_rx;
		logic           endless_tx;
		logic [8:0]     tx_len;
		logic           payload_bit;
		logic           payload_prbs;
	} rtc_state_s;

	localparam rtc_state_s RTC_STATE_RST = '{
		bus     : RTC_BUS_IDLE,
		waitreq : 1'b1,
		tim     : rtc_timgen_s'(RTC_TIMGEN_RST),
		coex    : rtc_coex_s'(RTC_COEX_RST),
		default : '0
	};

endpackage : rtc_pkg

// File: hdl/rtc_prbs.sv
// Purpose: Fibonacci pseudo-random sequence generator, one bit per step.
// Assumes: Polynomial x^LEN + x^TAP + 1; seed of all ones.
// Notes:   The seed can never be the all-zero lock-up state.
`timescale 1ns/10ps
module rtc_prbs
#(
	parameter int LEN = 9,
	parameter int TAP = 5
)
(
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic ce_i,
	input  wire logic step_i,
	output logic      bit_o
);

	typedef struct packed {
		logic [LEN-1:0] lfsr;
	} rtc_prbs_state_s;

	rtc_prbs_state_s st_reg;
	rtc_prbs_state_s st_next;

	if (LEN < 2 || TAP < 1 || TAP >= LEN)
	begin : g_bad_param
		$error("rtc_prbs: tap must lie strictly inside the register length");
	end

	always_comb
	begin
		st_next = st_reg;
		if (step_i)
		begin
			st_next.lfsr = {st_reg.lfsr[LEN-2:0], st_reg.lfsr[LEN-1] ^ st_reg.lfsr[TAP-1]};
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			st_reg <= '{lfsr: '1};
		else if (ce_i)
			st_reg <= st_next;
	end

	assign bit_o = st_reg.lfsr[LEN-1];

endmodule : rtc_prbs

// File: hdl/rtc_regs.sv
// Purpose: Test-mode, timing-generator and coexistence register slice of the radio baseband.
// Assumes: Radio and timer events arrive on clk_i; the peer arbiter lines are asynchronous pins.
// Notes:   Avalon-MM slave with one wait state; every output is registered.
`timescale 1ns/10ps
module rtc_regs
	import rtc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        ce_i,
	input  wire logic [31:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        rf_test_mode_i,
	input  wire logic        rf_abort_i,
	input  wire logic        tx_pkt_done_i,
	input  wire logic        rx_pkt_done_i,
	input  wire logic        rx_sync_err_i,
	input  wire logic        rx_crc_err_i,
	input  wire logic        rx_tag_valid_i,
	input  wire logic [31:0] rx_tag_i,
	input  wire logic [8:0]  descriptor_payload_size_i,
	input  wire logic        payload_step_i,
	input  wire logic [26:0] base_time_counter_i,
	input  wire logic        tx_en_i,
	input  wire logic        tx_pwrup_i,
	input  wire logic        tx_high_prio_i,
	input  wire logic        rx_corr_en_i,
	input  wire logic        rx_pwrup_i,
	input  wire logic        rx_high_prio_i,
	input  wire logic        sync_event_i,
	input  wire logic        peer_tx_i,
	input  wire logic        peer_rx_i,
	output logic             endless_rx_o,
	output logic             endless_tx_o,
	output logic      [8:0]  tx_len_o,
	output logic             payload_prbs_o,
	output logic             payload_bit_o,
	output logic             early_fetch_abort_en_o,
	output logic      [8:0]  table_fetch_instant_o,
	output logic      [9:0]  fetch_abort_instant_o,
	output logic             coarse_alarm_o,
	output logic             fine_alarm_o,
	output logic             coex_tx_o,
	output logic             coex_rx_o,
	output logic             tx_abort_o,
	output logic             rx_abort_o,
	output logic             sync_pulse_o
);

	rtc_state_s st_reg;
	rtc_state_s st_next;
	logic       prbs9_bit;
	logic       prbs15_bit;
	logic       prbs_step;
	logic       coarse_match;
	logic       fine_match;
	logic       bus_wr;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wmask);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++)
		begin
			m[i*8 +: 8] = {8{avs_byteenable_i[i]}};
		end
		m = m & wmask;
		return (old & ~m) | (avs_writedata_i & m);
	endfunction : merge

	function automatic logic indicator(input rtc_ind_e mode, input logic pwrup, input logic active,
		input logic hiprio);
		logic v;
		v = 1'b0;
		case (mode)
			RTC_IND_NO_PWRUP:   v = active;
			RTC_IND_WITH_PWRUP: v = active | pwrup;
			RTC_IND_HIGH_PRIO:  v = hiprio;
			default:            v = 1'b0;
		endcase
		return v;
	endfunction : indicator

	// ----------------------------------------------------------------
	// Payload generators
	// ----------------------------------------------------------------
	// Both generators are kept so that flipping the polynomial select mid-test needs no reseed.
	assign prbs_step = rf_test_mode_i & st_reg.test.tx_payload_origin & payload_step_i;

	rtc_prbs #(.LEN(RTC_PRBS9_LEN), .TAP(RTC_PRBS9_TAP)) u_prbs9
	(
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.step_i    (prbs_step),
		.bit_o     (prbs9_bit)
	);

	rtc_prbs #(.LEN(RTC_PRBS15_LEN), .TAP(RTC_PRBS15_TAP)) u_prbs15
	(
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.step_i    (prbs_step),
		.bit_o     (prbs15_bit)
	);

	assign coarse_match = (st_reg.coarse_alarm_value == base_time_counter_i[26:4])
		&& (base_time_counter_i[3:0] == 4'h0);
	assign fine_match   = (st_reg.fine_alarm_value == base_time_counter_i);
	assign bus_wr       = (st_reg.bus == RTC_BUS_ANSWER) && avs_write_i;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;

		// Bus slave: the request is latched in the idle cycle and answered one cycle later.
		case (st_reg.bus)
			RTC_BUS_IDLE:
			begin
				if (avs_read_i || avs_write_i)
				begin
					st_next.bus     = RTC_BUS_ANSWER;
					st_next.waitreq = 1'b0;
					case (avs_address_i)
						RTC_ADR_RX_TAG:    st_next.rdata = st_reg.rx_integrity_tag;
						RTC_ADR_TEST_CTRL: st_next.rdata = st_reg.test;
						RTC_ADR_TX_TOTAL:  st_next.rdata = st_reg.tx_sent_total;
						RTC_ADR_RX_TOTAL:  st_next.rdata = st_reg.rx_good_total;
						RTC_ADR_TIMGEN:    st_next.rdata = st_reg.tim;
						RTC_ADR_COARSE:    st_next.rdata = {9'h000, st_reg.coarse_alarm_value};
						RTC_ADR_FINE:      st_next.rdata = {5'h00, st_reg.fine_alarm_value};
						RTC_ADR_CAPTURE:   st_next.rdata = {31'h00000000, st_reg.capture_time_trigger};
						RTC_ADR_COEX:      st_next.rdata = st_reg.coex;
						RTC_ADR_CAPT_VAL:  st_next.rdata = {5'h00, st_reg.captured_time};
						default:           st_next.rdata = 32'h00000000;
					endcase
				end
			end
			RTC_BUS_ANSWER:
			begin
				st_next.bus     = RTC_BUS_IDLE;
				st_next.waitreq = 1'b1;
			end
			default:
			begin
				st_next.bus     = RTC_BUS_IDLE;
				st_next.waitreq = 1'b1;
			end
		endcase

		// Time capture: the trigger lasts one cycle, then the device drops it.
		if (st_reg.capture_time_trigger)
		begin
			st_next.captured_time        = base_time_counter_i;
			st_next.capture_time_trigger = 1'b0;
		end

		// Register writes; read-only addresses fall through and change nothing.
		if (bus_wr)
		begin
			case (avs_address_i)
				RTC_ADR_TEST_CTRL: st_next.test = rtc_test_ctrl_s'(merge(st_reg.test, RTC_TEST_WMASK));
				RTC_ADR_TIMGEN:    st_next.tim  = rtc_timgen_s'(merge(st_reg.tim, RTC_TIMGEN_WMASK));
				RTC_ADR_COARSE:
					st_next.coarse_alarm_value = 23'(merge({9'h000, st_reg.coarse_alarm_value}, RTC_COARSE_WMASK));
				RTC_ADR_FINE:
					st_next.fine_alarm_value = 27'(merge({5'h00, st_reg.fine_alarm_value}, RTC_FINE_WMASK));
				RTC_ADR_CAPTURE:
				begin
					if (avs_byteenable_i[0] && avs_writedata_i[RTC_CAPTURE_BIT])
						st_next.capture_time_trigger = 1'b1;
				end
				RTC_ADR_COEX:      st_next.coex = rtc_coex_s'(merge(st_reg.coex, RTC_COEX_WMASK));
				default:           st_next.rdata = st_reg.rdata;
			endcase
		end

		if (rx_tag_valid_i)
			st_next.rx_integrity_tag = rx_tag_i;

		// Test counters run live and are published to software only on an abort command.
		if (!st_reg.test.tx_sent_count_enable)
			st_next.tx_live = 32'h00000000;
		else if (rf_test_mode_i && tx_pkt_done_i)
			st_next.tx_live = st_reg.tx_live + 32'h00000001;
		if (!st_reg.test.rx_good_count_enable)
			st_next.rx_live = 32'h00000000;
		else if (rf_test_mode_i && rx_pkt_done_i && !rx_sync_err_i && !rx_crc_err_i)
			st_next.rx_live = st_reg.rx_live + 32'h00000001;
		if (rf_abort_i && rf_test_mode_i)
		begin
			if (st_reg.test.tx_sent_count_enable)
				st_next.tx_sent_total = st_next.tx_live;
			if (st_reg.test.rx_good_count_enable)
				st_next.rx_good_total = st_next.rx_live;
		end

		// Test-mode controls toward the radio only act while the radio is in test mode.
		st_next.endless_rx   = rf_test_mode_i & st_reg.test.endless_receive_window;
		st_next.endless_tx   = rf_test_mode_i & st_reg.test.endless_transmit_payload;
		st_next.tx_len       = (rf_test_mode_i && st_reg.test.tx_size_select) ?
			st_reg.test.test_tx_byte_count : descriptor_payload_size_i;
		st_next.payload_prbs = rf_test_mode_i & st_reg.test.tx_payload_origin;
		st_next.payload_bit  = st_reg.test.pseudo_random_poly_select ? prbs15_bit : prbs9_bit;

		// Alarms pulse once on entering a match, since the counter holds a value for many cycles.
		st_next.coarse_hit   = coarse_match;
		st_next.fine_hit     = fine_match;
		st_next.coarse_alarm = coarse_match & ~st_reg.coarse_hit;
		st_next.fine_alarm   = fine_match & ~st_reg.fine_hit;

		// Coexistence port.
		st_next.peer_tx_sync = {st_reg.peer_tx_sync[0], peer_tx_i};
		st_next.peer_rx_sync = {st_reg.peer_rx_sync[0], peer_rx_i};
		st_next.coex_rx = st_reg.coex.coexist_port_enable & indicator(st_reg.coex.rx_coex_indicator_mode,
			rx_pwrup_i, rx_corr_en_i, rx_high_prio_i);
		st_next.coex_tx = st_reg.coex.coexist_port_enable & indicator(st_reg.coex.tx_coex_indicator_mode,
			tx_pwrup_i, tx_en_i, tx_high_prio_i);
		st_next.tx_abort = st_reg.coex.coexist_port_enable
			& ((st_reg.peer_tx_sync[1] & st_reg.coex.peer_transmit_block_policy[0])
			| (st_reg.peer_rx_sync[1] & st_reg.coex.peer_receive_block_policy[0]));
		st_next.rx_abort = st_reg.coex.coexist_port_enable
			& ((st_reg.peer_tx_sync[1] & st_reg.coex.peer_transmit_block_policy[1])
			| (st_reg.peer_rx_sync[1] & st_reg.coex.peer_receive_block_policy[1]));
		st_next.sync_pulse = st_reg.coex.coexist_port_enable & st_reg.coex.sync_pulse_enable
			& sync_event_i;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			st_reg <= RTC_STATE_RST;
		else if (ce_i)
			st_reg <= st_next;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign avs_readdata_o         = st_reg.rdata;
	assign avs_waitrequest_o      = st_reg.waitreq;
	assign endless_rx_o           = st_reg.endless_rx;
	assign endless_tx_o           = st_reg.endless_tx;
	assign tx_len_o               = st_reg.tx_len;
	assign payload_prbs_o         = st_reg.payload_prbs;
	assign payload_bit_o          = st_reg.payload_bit;
	assign early_fetch_abort_en_o = st_reg.tim.early_fetch_abort_enable;
	assign table_fetch_instant_o  = st_reg.tim.table_fetch_instant;
	assign fetch_abort_instant_o  = st_reg.tim.fetch_abort_instant;
	assign coarse_alarm_o         = st_reg.coarse_alarm;
	assign fine_alarm_o           = st_reg.fine_alarm;
	assign coex_tx_o              = st_reg.coex_tx;
	assign coex_rx_o              = st_reg.coex_rx;
	assign tx_abort_o             = st_reg.tx_abort;
	assign rx_abort_o             = st_reg.rx_abort;
	assign sync_pulse_o           = st_reg.sync_pulse;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	AST_TAG_LOAD: assert property (ce_i && rx_tag_valid_i |=> st_reg.rx_integrity_tag == $past(rx_tag_i))
		else $error("integrity tag not loaded");
	AST_ENDLESS_RX: assert property (ce_i
		|=> endless_rx_o == $past(rf_test_mode_i && st_reg.test.endless_receive_window))
		else $error("endless receive output wrong");
	AST_ENDLESS_TX: assert property (ce_i && !rf_test_mode_i |=> !endless_tx_o && !payload_prbs_o)
		else $error("test control active outside test mode");
	AST_TX_LEN: assert property (ce_i && rf_test_mode_i && st_reg.test.tx_size_select
		|=> tx_len_o == $past(st_reg.test.test_tx_byte_count))
		else $error("test length not selected");
	AST_TX_PUBLISH: assert property (ce_i && rf_abort_i && rf_test_mode_i && !tx_pkt_done_i
		&& st_reg.test.tx_sent_count_enable |=> st_reg.tx_sent_total == $past(st_reg.tx_live))
		else $error("transmit total not published on abort");
	AST_RX_BAD: assert property (ce_i && st_reg.test.rx_good_count_enable && rx_pkt_done_i
		&& (rx_sync_err_i || rx_crc_err_i) |=> $stable(st_reg.rx_live))
		else $error("errored packet was counted");
	AST_COARSE: assert property ($past(ce_i) && coarse_alarm_o
		|-> $past(coarse_match) && !$past(st_reg.coarse_hit))
		else $error("coarse alarm without match");
	AST_FINE: assert property (ce_i && fine_match && !st_reg.fine_hit
		|=> fine_alarm_o ##1 (!$past(ce_i) || !fine_alarm_o))
		else $error("fine alarm not a single pulse");
	AST_CAPTURE: assert property (ce_i && st_reg.capture_time_trigger && !bus_wr
		|=> !st_reg.capture_time_trigger && st_reg.captured_time == $past(base_time_counter_i))
		else $error("capture trigger did not act and clear");
	AST_COEX_OFF: assert property (ce_i && !st_reg.coex.coexist_port_enable
		|=> !coex_tx_o && !coex_rx_o && !tx_abort_o && !rx_abort_o && !sync_pulse_o)
		else $error("coexistence output while port disabled");
	AST_RO_WRITE: assert property (ce_i && bus_wr && avs_address_i == RTC_ADR_TX_TOTAL && !rf_abort_i
		|=> $stable(st_reg.tx_sent_total))
		else $error("read-only total changed by write");
	AST_ANSWER: assert property (ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus answer late");

endmodule : rtc_regs

// File: tb/rtc_peer_model.sv
// Purpose: Behavioural peer coexistence arbiter that drives the two peer activity pins.
// Assumes: The bench commands each pin level; the arbiter launches it on a clock edge.
// Notes:   Both pins are push-pull and active high, so no released level exists.
`timescale 1ns/10ps
module rtc_peer_model
(
	input  wire logic clk_i,
	input  wire logic tx_cmd_i,
	input  wire logic rx_cmd_i,
	output logic      peer_tx_o,
	output logic      peer_rx_o
);
	always @(posedge clk_i)
	begin
		peer_tx_o <= tx_cmd_i;
		peer_rx_o <= rx_cmd_i;
	end
endmodule : rtc_peer_model

// File: tb/rtc_regs_tb.sv
// Purpose: Self-checking bench for the radio test, timer and coexistence register slice.
// Assumes: Avalon-MM answers after one wait cycle; outputs follow inputs one cycle later, the abort outputs three cycles after the peer pins.
// Notes:   Byte enables and the receive power-up source are held constant.
`timescale 1ns/10ps
module rtc_regs_tb;
	import rtc_pkg::*;
	logic clk_i, reset_n_i, avs_read_i, avs_write_i, rf_test_mode_i, rf_abort_i, tx_pkt_done_i, rx_pkt_done_i;
	logic rx_sync_err_i, rx_crc_err_i, rx_tag_valid_i, payload_step_i, tx_en_i, tx_pwrup_i, rx_corr_en_i;
	logic sync_event_i, peer_tx_i, peer_rx_i, tx_cmd, rx_cmd, avs_waitrequest_o, endless_rx_o, endless_tx_o;
	logic payload_prbs_o, payload_bit_o, early_fetch_abort_en_o, coarse_alarm_o, fine_alarm_o, coex_tx_o;
	logic coex_rx_o, tx_abort_o, rx_abort_o, sync_pulse_o, ce_i, tx_high_prio_i, rx_high_prio_i;
	logic [31:0] avs_address_i, avs_writedata_i, rx_tag_i, avs_readdata_o, q;
	logic [26:0] base_time_counter_i;
	logic [8:0]  descriptor_payload_size_i, tx_len_o, table_fetch_instant_o;
	logic [9:0]  fetch_abort_instant_o;
	int          errors, checks_done, n, c;
	logic [31:0] ra [8] = '{RTC_ADR_TEST_CTRL, RTC_ADR_TIMGEN, RTC_ADR_COARSE, RTC_ADR_FINE, RTC_ADR_COEX,
		RTC_ADR_RX_TAG, RTC_ADR_TX_TOTAL, 32'h40000200};
	logic [31:0] re [8] = '{RTC_TEST_WMASK, RTC_TIMGEN_WMASK, RTC_COARSE_WMASK, RTC_FINE_WMASK, RTC_COEX_WMASK,
		32'h0, 32'h0, 32'h0};
	rtc_peer_model u_peer (.clk_i, .tx_cmd_i(tx_cmd), .rx_cmd_i(rx_cmd), .peer_tx_o(peer_tx_i), .peer_rx_o(peer_rx_i));
	rtc_regs u_dut (.clk_i, .reset_n_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .rf_test_mode_i, .rf_abort_i, .tx_pkt_done_i,
		.rx_pkt_done_i, .rx_sync_err_i, .rx_crc_err_i, .rx_tag_valid_i, .rx_tag_i, .descriptor_payload_size_i,
		.payload_step_i, .base_time_counter_i, .tx_en_i, .tx_pwrup_i, .tx_high_prio_i, .rx_corr_en_i,
		.rx_pwrup_i(1'b0), .rx_high_prio_i, .sync_event_i, .peer_tx_i, .peer_rx_i, .endless_rx_o,
		.endless_tx_o, .tx_len_o, .payload_prbs_o, .payload_bit_o, .early_fetch_abort_en_o, .table_fetch_instant_o,
		.fetch_abort_instant_o, .coarse_alarm_o, .fine_alarm_o, .coex_tx_o, .coex_rx_o, .tx_abort_o, .rx_abort_o,
		.sync_pulse_o);
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task tally_and_finish;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask : chk
	// The request stays up until waitrequest is seen low; after 20 cycles without an answer the bench counts an error and finishes.
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_address_i <= a;
		avs_writedata_i <= d;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0)
				break;
		end
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (n == 20)
		begin
			errors++;
			tally_and_finish();
		end
	endtask : bus
	// Alarms and sync are single-cycle pulses, so they are counted over a short window.
	task pulses(input int sel);
		c = 0;
		repeat (4)
		begin
			@(posedge clk_i);
			c += (sel == 0) ? coarse_alarm_o : (sel == 1) ? fine_alarm_o : sync_pulse_o;
		end
	endtask : pulses
	// The polynomial's recurrence holds at any phase of the sequence, so no seed alignment is needed.
	task prbs_chk(input string nm, input int len, input int tap);
		logic [39:0] pb;
		int          bad;
		bad = 0;
		repeat (41)
		begin
			@(posedge clk_i);
			pb = {pb[38:0], payload_bit_o};
		end
		for (int k = 0; k + len < 40; k++)
			bad += (pb[k] !== (pb[k + len] ^ pb[k + tap]));
		chk(nm, 32'h0, bad + (pb == '0));
	endtask : prbs_chk
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{avs_read_i, avs_write_i, rf_test_mode_i, rf_abort_i, tx_pkt_done_i, rx_pkt_done_i, rx_sync_err_i} = '0;
		{rx_crc_err_i, rx_tag_valid_i, payload_step_i, tx_en_i, tx_pwrup_i, rx_corr_en_i, sync_event_i} = '0;
		{tx_high_prio_i, rx_high_prio_i, ce_i} = 3'b001;
		{tx_cmd, rx_cmd, avs_address_i, avs_writedata_i, base_time_counter_i} = '0;
		rx_tag_i = 32'hC0FFEE11;
		descriptor_payload_size_i = 9'h0AA;
		errors = 0;
		checks_done = 0;
		reset_n_i = 1'b0;
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b1, ra[i], 32'hFFFFFFFF);
			bus(1'b0, ra[i], 32'h0);
			chk("readback", re[i], q);
		end
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		chk("fetch fields", 20'hBFC96, {early_fetch_abort_en_o, fetch_abort_instant_o, table_fetch_instant_o});
		bus(1'b0, RTC_ADR_TIMGEN, 32'h0);
		chk("timgen reset", 32'h81FE0096, q);
		bus(1'b0, RTC_ADR_COEX, 32'h0);
		chk("coex reset", 32'h00000010, q);
		bus(1'b1, RTC_ADR_TEST_CTRL, 32'h8000F1FF);
		payload_step_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("test idle", 12'h0AA, {endless_rx_o, endless_tx_o, payload_prbs_o, tx_len_o});
		rf_test_mode_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("test on", 12'hFFF, {endless_rx_o, endless_tx_o, payload_prbs_o, tx_len_o});
		prbs_chk("prbs15", RTC_PRBS15_LEN, RTC_PRBS15_TAP);
		bus(1'b1, RTC_ADR_TEST_CTRL, 32'h8000D1FF);
		prbs_chk("prbs9", RTC_PRBS9_LEN, RTC_PRBS9_TAP);
		bus(1'b1, RTC_ADR_TEST_CTRL, 32'h08000800);
		payload_step_i <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			{tx_pkt_done_i, rx_pkt_done_i, rx_crc_err_i, rx_sync_err_i, rx_tag_valid_i} <= {2'b11, i == 1, i == 2, 1'b1};
			@(posedge clk_i);
			{tx_pkt_done_i, rx_pkt_done_i, rx_crc_err_i, rx_sync_err_i, rx_tag_valid_i} <= '0;
			@(posedge clk_i);
		end
		rf_abort_i <= 1'b1;
		@(posedge clk_i);
		rf_abort_i <= 1'b0;
		bus(1'b0, RTC_ADR_TX_TOTAL, 32'h0);
		chk("tx total", 32'h4, q);
		bus(1'b0, RTC_ADR_RX_TOTAL, 32'h0);
		chk("rx total", 32'h2, q);
		bus(1'b0, RTC_ADR_RX_TAG, 32'h0);
		chk("rx tag", 32'hC0FFEE11, q);
		base_time_counter_i <= 27'h5A5A5A5;
		bus(1'b1, RTC_ADR_CAPTURE, 32'h1);
		bus(1'b0, RTC_ADR_CAPT_VAL, 32'h0);
		chk("captured", 32'h05A5A5A5, q);
		bus(1'b0, RTC_ADR_CAPTURE, 32'h0);
		chk("capture bit", 32'h0, q);
		bus(1'b1, RTC_ADR_COARSE, 32'h00012345);
		bus(1'b1, RTC_ADR_FINE, 32'h00000777);
		base_time_counter_i <= {23'h12345, 4'h1};
		pulses(0);
		chk("coarse low nibble", 32'h0, c);
		base_time_counter_i <= {23'h12345, 4'h0};
		pulses(0);
		chk("coarse hit", 32'h1, c);
		base_time_counter_i <= 27'h777;
		pulses(1);
		chk("fine hit", 32'h1, c);
		bus(1'b1, RTC_ADR_COEX, 32'h000000F1);
		tx_cmd <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("peer tx aborts", 2'b11, {tx_abort_o, rx_abort_o});
		tx_cmd <= 1'b0;
		bus(1'b1, RTC_ADR_COEX, 32'h00000013);
		rx_cmd <= 1'b1;
		sync_event_i <= 1'b1;
		@(posedge clk_i);
		sync_event_i <= 1'b0;
		pulses(2);
		chk("sync pulse", 32'h1, c);
		chk("peer rx aborts", 2'b10, {tx_abort_o, rx_abort_o});
		bus(1'b1, RTC_ADR_COEX, 32'h000000F0);
		repeat (3) @(posedge clk_i);
		chk("coex off", 2'b00, {tx_abort_o, rx_abort_o});
		{tx_pwrup_i, rx_corr_en_i, rx_high_prio_i} <= 3'b111;
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, RTC_ADR_COEX, (i << 20) | (i << 16) | 1);
			repeat (2) @(posedge clk_i);
			chk("indicators", 8'h1D >> (2 * i) & 2'b11, {coex_tx_o, coex_rx_o});
		end
		// A tag offered while the clock enable is low must not be taken.
		{ce_i, rx_tag_valid_i, rx_tag_i} <= {2'b01, 32'h12345678};
		repeat (2) @(posedge clk_i);
		{ce_i, rx_tag_valid_i} <= 2'b10;
		bus(1'b0, RTC_ADR_RX_TAG, 32'h0);
		chk("frozen tag", 32'hC0FFEE11, q);
		tally_and_finish();
	end
endmodule : rtc_regs_tb
